// *** emc_defs.svh ***
`ifndef EMC_DEFS_SVH
`define EMC_DEFS_SVH
// Energy state encodings of the state select field
`define EMC_SEL_FULL 2'h0
`define EMC_SEL_REDUCED 2'h2
`define EMC_SEL_MINIMAL 2'h3
// Direct pin levels {clock, data} per state
`define EMC_PIN_FULL 2'h3
`define EMC_PIN_REDUCED 2'h1
`define EMC_PIN_MINIMAL 2'h0
// Pin pair level while idle under pull-ups
`define EMC_PIN_IDLE 2'h3
// Number of outputs with a coarse regulator
`define EMC_NUM_OUT 3
// Pacing counter reset value
`define EMC_PACE_ZERO 8'h00
// Settings field reset value
`define EMC_FIELD_ZERO 4'h0
`endif

// *** emc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// Host driving the serial pins as state levels
module emc_host (
	output logic o_scl,
	output logic o_sda
);
	initial {o_scl, o_sda} = 2'b11;
	// holds a level one link period
	task automatic put(input logic [1:0] lv);
		{o_scl, o_sda} = lv;
		#400;
	endtask
	// full and minimal meet via reduced
	task automatic go(input logic [1:0] lv);
		if (({o_scl, o_sda} ^ lv) == 2'b11) put(2'b01);
		put(lv);
	endtask
	// start from full, back to full
	task automatic start;
		put(2'b10);
		put(2'b11);
	endtask
endmodule // emc_host
`default_nettype wire

// *** emc_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "emc_defs.svh"
// Ties energy state outputs to their causes
module emc_monitor (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_sel_wr,
	input wire logic [1:0] i_state_select_field,
	input wire logic i_pin_control_enable_wr,
	input wire logic i_start_forces_full_power,
	input wire logic [`EMC_NUM_OUT-1:0] i_coarse_output_enable,
	input wire logic i_auto_bypass_disable,
	input wire logic [1:0] i_force_bypass_bit,
	input wire logic [1:0] i_low_input,
	input wire logic [1:0] o_state,
	input wire logic o_pin_control_active,
	input wire logic o_pullup_enable,
	input wire logic [1:0] o_conv_run,
	input wire logic [`EMC_NUM_OUT-1:0] o_coarse_on,
	input wire logic [1:0] o_reg_bypass,
	input wire logic o_measure_enable,
	input wire logic o_irq
);
	// One domain, reset disables all
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// Accepted write shows two edges later
	property p_sel; i_sel_wr && !i_pin_control_enable_wr && !$past(i_pin_control_enable_wr)
		&& !o_pin_control_active && i_state_select_field != 2'h1
		|-> ##2 o_state == $past(i_state_select_field, 2); endproperty
	a_sel: assert property (p_sel) else $error("written state not taken");
	property p_pull; o_pullup_enable == !o_pin_control_active; endproperty
	a_pull: assert property (p_pull) else $error("pull-up wrong");
	property p_rst; $rose(i_rst_n) |-> o_state == 2'h0 && o_measure_enable; endproperty
	a_rst: assert property (p_rst) else $error("not full after reset");
	property p_min; o_state == 2'h3
		|-> o_conv_run == 2'h0 && o_coarse_on == $past(i_coarse_output_enable); endproperty
	a_min: assert property (p_min) else $error("minimal outputs wrong");
	property p_quiet; o_state == 2'h3 |-> !o_measure_enable && !o_irq; endproperty
	a_quiet: assert property (p_quiet) else $error("activity in minimal");
	// Pins stable five edges give the decoded state
	property p_pin_hi; (o_pin_control_active && i_sda && $stable(i_scl)) [*5]
		|=> o_state == ($past(i_scl) ? 2'h0 : 2'h2); endproperty
	a_pin_hi: assert property (p_pin_hi) else $error("pin decode wrong");
	property p_pin_lo; (o_pin_control_active && !i_scl && !i_sda) [*5]
		|=> o_state == 2'h3; endproperty
	a_pin_lo: assert property (p_pin_lo) else $error("pin minimal wrong");
	// Start level seen on the raw pins
	sequence s_start; o_pin_control_active && i_scl && $past(i_scl) && $fell(i_sda); endsequence
	property p_start; s_start |-> ##[1:6] !o_pin_control_active; endproperty
	a_start: assert property (p_start) else $error("pin mode kept");
	// Force applies in register control as well
	property p_force; i_scl && $past(i_scl) && $fell(i_sda) && i_start_forces_full_power
		|-> ##[1:6] o_state == 2'h0; endproperty
	a_force: assert property (p_force) else $error("start not full");
	// Bypass follows force bit or low input
	property p_byp; $past(i_rst_n) && o_state != 2'h3
		|-> o_reg_bypass == ($past(i_force_bypass_bit)
		| ($past(i_low_input) & ~{2{$past(i_auto_bypass_disable)}})); endproperty
	a_byp: assert property (p_byp) else $error("bypass wrong");
	c_min: cover property (o_state == 2'h3);
	c_pin: cover property (o_pin_control_active && o_state == 2'h2);
	c_start: cover property ($fell(o_pin_control_active));
endmodule // emc_monitor
bind emc_top emc_monitor emc_monitor_inst (.*);
`default_nettype wire

// *** emc_pace_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Links the top to one regulator pacing unit
interface emc_pace_if #(parameter int W = 4);
	logic run; // Regulator allowed to pulse
	logic [W-1:0] pace; // Pacing field
	logic req; // Pulse request from regulation loop
	logic start; // Granted pulse start
	modport top (output run, output pace, output req, input start);
	modport unit (input run, input pace, input req, output start);
endinterface
`default_nettype wire

// *** emc_pacer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "emc_defs.svh"
// Minimum spacing of regulator pulse starts
module emc_pacer #(parameter int W = 4) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_tick,
	emc_pace_if.unit bus
);
	logic [W:0] gap_q; // Remaining ticks until next start allowed
	// Start only when gap has elapsed
	assign bus.start = bus.run && bus.req && (gap_q == '0);
	// Gap counter, loaded with 2*field per start
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			gap_q <= '0;
		end else if (bus.start) begin
			gap_q <= {bus.pace, 1'b0};
		end else if (i_tick && gap_q != '0) begin
			gap_q <= gap_q - 1'b1;
		end
	end
endmodule // emc_pacer
`default_nettype wire

// *** emc_pkg.sv ***
package emc_pkg;
	// Energy states of the device
	typedef enum logic [1:0] {
		EMC_FULL,
		EMC_REDUCED,
		EMC_MINIMAL
	} emc_state_t;
endpackage

// *** emc_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "emc_defs.svh"
// Two flip-flop synchroniser for pin levels
module emc_sync #(parameter int W = 2) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_q; // First stage, read only by second
	// Idle high like a pulled-up bus
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= '1;
			o_sync <= '1;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule // emc_sync
`default_nettype wire

// *** emc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "emc_defs.svh"
// Overview of operation
// R1: Written state select moves device state
// R2: Pull-ups stay on in register control
// R3: Pin mode drops pull-ups, pins select
// R4: Pin decode 11 full, 01 reduced, 00 minimal
// R5: Start condition ends pin control mode
// R6: Start forces full power when enabled
// R7: Host passes through reduced bias only
// R8: Reset enters full power, all enabled; reset loads o_conv_run, o_reg_run 0 until the first clock
// R9: Reduced state uses reduced current, voltage
// R10: Second output charge split by state
// R11: Boost no-adjust keeps peak in reduced
// R12: Minimal disables converters, enables coarse
// R13: Minimal suspends measurements and counting
// R14: Minimal never raises interrupt request
// R15: Coarse bypass shorts outputs to input
// R16: Automatic bypass unless disable bit set
// R17: Force bypass shorts each regulator
// R18: Pulse starts spaced by pacing field
// R19: Host clears pacing once in regulation
// R20: Dropout threshold picks linear operation
// R21: Pin levels synchronised before decode
module emc_top #(
	parameter int PACE_W = 4, // Pacing field width
	parameter int IPK_W = 4, // Peak current field width
	parameter int VOUT_W = 6, // Target voltage field width
	parameter int THR_W = 4 // Dropout threshold width
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_scl, // Serial clock pin level
	input wire logic i_sda, // Serial data pin level
	input wire logic i_sel_wr, // Register write strobe of state select
	input wire logic [1:0] i_state_select_field, // Written state
	input wire logic i_pin_control_enable_wr, // Write strobe of pin mode bit
	input wire logic i_pin_control_enable, // Pin mode bit value
	input wire logic i_start_forces_full_power, // Start forces full power
	input wire logic [`EMC_NUM_OUT-1:0] i_coarse_output_enable, // Per output
	input wire logic i_coarse_bypass_bit, // Short coarse outputs
	input wire logic i_auto_bypass_disable, // Suppress auto bypass
	input wire logic [1:0] i_force_bypass_bit, // Second, third regulator
	input wire logic [1:0] i_low_input, // Input too low for regulation
	input wire logic [PACE_W-1:0] i_second_pulse_pacing,
	input wire logic [PACE_W-1:0] i_third_pulse_pacing,
	input wire logic [1:0] i_pulse_req, // Regulator pulse requests
	input wire logic i_pace_tick, // Slow pacing enable pulse
	input wire logic [IPK_W-1:0] i_first_peak_current,
	input wire logic [IPK_W-1:0] i_first_reduced_peak_current,
	input wire logic [IPK_W-1:0] i_second_peak_current,
	input wire logic [IPK_W-1:0] i_second_reduced_peak_current,
	input wire logic i_boost_mode, // First converter in boost mode
	input wire logic i_boost_peak_no_adjust,
	input wire logic [VOUT_W-1:0] i_second_target_voltage,
	input wire logic [VOUT_W-1:0] i_second_reduced_target_voltage,
	input wire logic [1:0] i_conv_enable, // Switching converters enabled
	input wire logic [1:0] i_reg_enable, // Linear regulators enabled
	input wire logic [THR_W-1:0] i_first_dropout_threshold,
	input wire logic [THR_W-1:0] i_second_dropout_threshold,
	input wire logic [THR_W-1:0] i_first_dropout, // Measured headroom
	input wire logic [THR_W-1:0] i_second_dropout,
	input wire logic i_second_charge_pulse, // Charge pulse of second output
	input wire logic i_irq_event, // Interrupt request from status logic
	output logic [1:0] o_state, // Current energy state
	output logic o_pin_control_active, // Pin control mode on
	output logic o_pullup_enable, // Serial pin pull-ups on
	output logic [1:0] o_conv_run,
	output logic [1:0] o_reg_run,
	output logic [`EMC_NUM_OUT-1:0] o_coarse_on,
	output logic [`EMC_NUM_OUT-1:0] o_coarse_bypass,
	output logic [1:0] o_reg_bypass,
	output logic [1:0] o_pulse_start, // Paced pulse starts
	output logic [IPK_W-1:0] o_first_peak,
	output logic [IPK_W-1:0] o_second_peak,
	output logic [VOUT_W-1:0] o_second_target,
	output logic [1:0] o_linear_mode, // Pair runs linear
	output logic o_measure_enable, // ADC measurements allowed
	output logic o_count_enable, // Charge counting allowed
	output logic o_charge_to_reduced, // Second charge to reduced result
	output logic o_second_charge_full, // Pulse for full-power result
	output logic o_second_charge_reduced, // Pulse for reduced result
	output logic o_irq
);
	// Refuse field widths the logic cannot serve
	if (PACE_W < 1 || IPK_W < 1 || VOUT_W < 1 || THR_W < 1) begin : g_bad_width
		$error("emc_top: field widths must be positive");
	end

	emc_pkg::emc_state_t state_q; // Energy state
	logic direct_q; // Pin control mode
	logic [1:0] pins_s; // Synchronised {scl, sda}
	logic [1:0] pins_q; // Previous synchronised pins
	logic start_det; // Start condition seen

	// R21: synchronise pin levels
	emc_sync #(.W(2)) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_async({i_scl, i_sda}),
		.o_sync(pins_s)
	);

	// Previous pin levels for edge detection
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			// Idle level, so no false start after reset
			pins_q <= `EMC_PIN_IDLE;
		end else begin
			pins_q <= pins_s;
		end
	end

	// R5: start is data fall while clock high
	assign start_det = pins_s[1] && pins_q[1] && pins_q[0] && !pins_s[0];

	// Pin control mode bit
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			direct_q <= 1'b0;
		end else if (direct_q && start_det) begin
			// R5: start clears pin mode
			direct_q <= 1'b0;
		end else if (i_pin_control_enable_wr) begin
			direct_q <= i_pin_control_enable;
		end
	end

	// Energy state selection
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			// R8: reset to full power
			state_q <= emc_pkg::EMC_FULL;
		end else if (start_det && i_start_forces_full_power) begin
			// R6: start forces full power
			state_q <= emc_pkg::EMC_FULL;
		end else if (direct_q) begin
			// R4: decode pin levels
			case (pins_s)
				`EMC_PIN_FULL: state_q <= emc_pkg::EMC_FULL;
				`EMC_PIN_REDUCED: state_q <= emc_pkg::EMC_REDUCED;
				`EMC_PIN_MINIMAL: state_q <= emc_pkg::EMC_MINIMAL;
				default: state_q <= state_q; // Start level keeps state
			endcase
		end else if (i_sel_wr) begin
			// R1: written state select
			case (i_state_select_field)
				`EMC_SEL_FULL: state_q <= emc_pkg::EMC_FULL;
				`EMC_SEL_REDUCED: state_q <= emc_pkg::EMC_REDUCED;
				`EMC_SEL_MINIMAL: state_q <= emc_pkg::EMC_MINIMAL;
				default: state_q <= state_q; // Unused code ignored
			endcase
		end
	end

	logic full_s, red_s, min_s; // State decodes
	assign full_s = (state_q == emc_pkg::EMC_FULL);
	assign red_s = (state_q == emc_pkg::EMC_REDUCED);
	assign min_s = (state_q == emc_pkg::EMC_MINIMAL);

	// Registered outputs
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_state <= `EMC_SEL_FULL;
			o_pin_control_active <= 1'b0;
			o_pullup_enable <= 1'b1;
			o_conv_run <= 2'h0;
			o_reg_run <= 2'h0;
			o_coarse_on <= '0;
			o_coarse_bypass <= '0;
			o_reg_bypass <= 2'h0;
			o_measure_enable <= 1'b1;
			o_count_enable <= 1'b1;
			o_charge_to_reduced <= 1'b0;
			o_irq <= 1'b0;
		end else begin
			case (state_q)
				emc_pkg::EMC_FULL: o_state <= `EMC_SEL_FULL;
				emc_pkg::EMC_REDUCED: o_state <= `EMC_SEL_REDUCED;
				emc_pkg::EMC_MINIMAL: o_state <= `EMC_SEL_MINIMAL;
				default: o_state <= `EMC_SEL_FULL;
			endcase
			o_pin_control_active <= direct_q;
			// R2: pull-ups on in register mode; R3: off in pin mode
			o_pullup_enable <= !direct_q;
			// R12: minimal stops converters and regulators
			o_conv_run <= min_s ? 2'h0 : i_conv_enable;
			o_reg_run <= min_s ? 2'h0 : i_reg_enable;
			// R12: coarse regulators by enable bits
			o_coarse_on <= min_s ? i_coarse_output_enable : '0;
			// R15: coarse bypass of enabled coarse regulators
			o_coarse_bypass <= (min_s && i_coarse_bypass_bit) ? i_coarse_output_enable : '0;
			// R16: auto bypass; R17: force bypass
			o_reg_bypass <= i_force_bypass_bit | (i_auto_bypass_disable ? 2'h0 : i_low_input);
			// R13: minimal suspends measurement and counting
			o_measure_enable <= !min_s;
			o_count_enable <= !min_s;
			// R10: second output charge routed by state
			o_charge_to_reduced <= red_s;
			// R14: no interrupt in minimal state
			o_irq <= i_irq_event && !min_s;
		end
	end

	// R10: charge pulses steered to result pairs
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_second_charge_full <= 1'b0;
			o_second_charge_reduced <= 1'b0;
		end else begin
			o_second_charge_full <= i_second_charge_pulse && full_s;
			o_second_charge_reduced <= i_second_charge_pulse && red_s;
		end
	end

	// R9: per-state converter settings; R11: no-adjust
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_first_peak <= '0;
			o_second_peak <= '0;
			o_second_target <= '0;
		end else begin
			if (red_s && !(i_boost_mode && i_boost_peak_no_adjust)) begin
				o_first_peak <= i_first_reduced_peak_current;
			end else begin
				o_first_peak <= i_first_peak_current;
			end
			o_second_peak <= red_s ? i_second_reduced_peak_current : i_second_peak_current;
			o_second_target <= red_s ? i_second_reduced_target_voltage : i_second_target_voltage;
		end
	end

	// R20: linear when headroom at or below threshold
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_linear_mode <= 2'h0;
		end else begin
			o_linear_mode[0] <= i_first_dropout <= i_first_dropout_threshold;
			o_linear_mode[1] <= i_second_dropout <= i_second_dropout_threshold;
		end
	end

	// R18: paced pulse starts for both regulators
	emc_pace_if #(.W(PACE_W)) pace_b ();
	emc_pace_if #(.W(PACE_W)) pace_c ();
	// Regulators may pulse only outside minimal state
	assign pace_b.run = !min_s && i_reg_enable[0];
	assign pace_b.pace = i_second_pulse_pacing;
	assign pace_b.req = i_pulse_req[0];
	assign pace_c.run = !min_s && i_reg_enable[1];
	assign pace_c.pace = i_third_pulse_pacing;
	assign pace_c.req = i_pulse_req[1];
	emc_pacer #(.W(PACE_W)) u_pace_b (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_tick(i_pace_tick),
		.bus(pace_b.unit)
	);
	emc_pacer #(.W(PACE_W)) u_pace_c (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_tick(i_pace_tick),
		.bus(pace_c.unit)
	);
	// Granted starts, combinational handshake
	assign o_pulse_start = {pace_c.start, pace_b.start};
endmodule // emc_top
`default_nettype wire

// *** emc_top_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
// Drives the controller and checks its outputs
module emc_top_bench;
	logic i_ref_clk, i_rst_n, i_scl, i_sda, i_sel_wr, i_pin_control_enable_wr;
	logic i_pin_control_enable, i_start_forces_full_power, i_coarse_bypass_bit, i_pace_tick;
	logic i_auto_bypass_disable, i_boost_mode, i_boost_peak_no_adjust, i_irq_event;
	logic i_second_charge_pulse, o_pin_control_active, o_pullup_enable, o_measure_enable;
	logic o_count_enable, o_charge_to_reduced, o_second_charge_full, o_second_charge_reduced;
	logic o_irq;
	logic [1:0] i_state_select_field, i_force_bypass_bit, i_low_input, i_pulse_req, o_state;
	logic [1:0] i_conv_enable, i_reg_enable, o_conv_run, o_reg_run, o_reg_bypass;
	logic [1:0] o_pulse_start, o_linear_mode;
	logic [2:0] i_coarse_output_enable, o_coarse_on, o_coarse_bypass;
	logic [3:0] i_second_pulse_pacing, i_third_pulse_pacing, i_first_peak_current;
	logic [3:0] i_first_reduced_peak_current, i_second_peak_current, o_first_peak;
	logic [3:0] i_second_reduced_peak_current, o_second_peak, i_first_dropout_threshold;
	logic [3:0] i_second_dropout_threshold, i_first_dropout, i_second_dropout;
	logic [5:0] i_second_target_voltage, i_second_reduced_target_voltage, o_second_target;
	int failures, compares, n0, n1;
	emc_top emc_top_inst (.*);
	emc_host emc_host_inst (.o_scl(i_scl), .o_sda(i_sda));
	// Compares one value and counts
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Waits edges, then the drive delay
	task automatic step(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	// One write strobe, select or pin mode
	task automatic wr(input logic pin, input logic [1:0] v);
		i_state_select_field = v;
		i_pin_control_enable = v[0];
		{i_sel_wr, i_pin_control_enable_wr} = {!pin, pin};
		step(1);
		{i_sel_wr, i_pin_control_enable_wr} = 2'b00;
		step(2);
	endtask
	task automatic stop_test;
		$display("Compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		i_ref_clk = 1'b0;
		forever #25 i_ref_clk = ~i_ref_clk;
	end
	// Cuts a hang short
	initial begin
		#100000;
		failures++;
		stop_test();
	end
	initial begin
		failures = 0;
		compares = 0;
		{i_rst_n, i_sel_wr, i_pin_control_enable_wr, i_pin_control_enable} = 4'h0;
		{i_start_forces_full_power, i_auto_bypass_disable, i_pace_tick, i_pulse_req} = 5'h00;
		{i_force_bypass_bit, i_low_input, i_state_select_field} = 6'h00;
		{i_second_pulse_pacing, i_third_pulse_pacing, i_second_charge_pulse} = 9'h000;
		{i_first_dropout_threshold, i_second_dropout_threshold} = 8'h00;
		{i_first_dropout, i_second_dropout} = 8'h00;
		{i_coarse_bypass_bit, i_boost_mode, i_boost_peak_no_adjust, i_irq_event} = 4'hf;
		{i_conv_enable, i_reg_enable, i_coarse_output_enable} = 7'h7d;
		{i_first_peak_current, i_first_reduced_peak_current} = 8'h59;
		{i_second_peak_current, i_second_reduced_peak_current} = 8'h6a;
		{i_second_target_voltage, i_second_reduced_target_voltage} = 12'h46b;
		step(5);
		i_rst_n = 1'b1;
		step(2);
		chk({o_state, o_measure_enable, o_count_enable, o_pullup_enable, o_irq}, 16'h000f);
		chk({o_conv_run, o_reg_run, o_first_peak, o_second_peak}, 16'h0f56);
		chk(o_second_target, 16'h0011);
		// Reduced bias, boost peak held
		wr(1'b0, 2'h2);
		chk({o_state, o_charge_to_reduced, o_pullup_enable}, 16'h000b);
		chk({o_first_peak, o_second_peak, 2'h0, o_second_target}, 16'h5a2b);
		i_boost_peak_no_adjust = 1'b0;
		step(2);
		chk(o_first_peak, 16'h0009);
		// Second output charge into reduced result
		i_second_charge_pulse = 1'b1;
		step(1);
		chk({o_second_charge_full, o_second_charge_reduced}, 16'h0001);
		// Minimal, then refused code, then full
		wr(1'b0, 2'h3);
		chk({o_state, o_conv_run, o_reg_run}, 16'h0030);
		chk({o_irq, o_measure_enable, o_count_enable}, 16'h0000);
		chk({o_second_charge_full, o_second_charge_reduced}, 16'h0000);
		chk({o_coarse_on, o_coarse_bypass, o_pullup_enable}, 16'h005b);
		wr(1'b0, 2'h1);
		chk(o_state, 16'h0003);
		wr(1'b0, 2'h0);
		chk({o_state, o_coarse_on}, 16'h0000);
		chk({o_second_charge_full, o_second_charge_reduced}, 16'h0002);
		i_second_charge_pulse = 1'b0;
		// Headroom above, then at, the threshold
		{i_first_dropout, i_second_dropout} = 8'h31;
		{i_first_dropout_threshold, i_second_dropout_threshold} = 8'h22;
		step(1);
		chk(o_linear_mode, 16'h0002);
		i_first_dropout = 4'h2;
		step(1);
		chk(o_linear_mode, 16'h0003);
		// Every bypass input combination
		for (int i = 0; i < 32; i++) begin
			{i_auto_bypass_disable, i_force_bypass_bit, i_low_input} = 5'(i);
			step(1);
			chk(o_reg_bypass, i_force_bypass_bit | (i_low_input & {2{!i_auto_bypass_disable}}));
		end
		{i_auto_bypass_disable, i_force_bypass_bit, i_low_input} = 5'h00;
		// Pacing fields two and zero
		{i_second_pulse_pacing, i_third_pulse_pacing, i_pace_tick, i_pulse_req} = 11'h107;
		step(1);
		n0 = 0;
		n1 = 0;
		repeat (25) begin
			n0 += o_pulse_start[0];
			n1 += o_pulse_start[1];
			step(1);
		end
		chk(16'(n0), 16'h0005);
		chk(16'(n1), 16'h0019);
		i_second_pulse_pacing = 4'h0;
		// Pin control walk
		wr(1'b1, 2'h1);
		chk({o_pin_control_active, o_pullup_enable}, 16'h0002);
		emc_host_inst.go(2'h1);
		chk(o_state, 16'h0002);
		emc_host_inst.go(2'h0);
		chk(o_state, 16'h0003);
		wr(1'b0, 2'h0);
		chk(o_state, 16'h0003);
		emc_host_inst.go(2'h3);
		chk(o_state, 16'h0000);
		i_start_forces_full_power = 1'b1;
		emc_host_inst.start();
		chk({o_pin_control_active, o_pullup_enable, o_state}, 16'h0004);
		// Register control start, force off then on
		i_start_forces_full_power = 1'b0;
		wr(1'b0, 2'h2);
		emc_host_inst.start();
		chk(o_state, 16'h0002);
		i_start_forces_full_power = 1'b1;
		emc_host_inst.start();
		chk({o_pin_control_active, o_state}, 16'h0000);
		stop_test();
	end
endmodule // emc_top_bench
`default_nettype wire
